// File: verilog/bbx_exec.v
// byte and bit instruction execute unit of an 8-bit core
`timescale 1ns/1ps
`include "bbx_map.vh"

module bbx_exec (
  input  wire        sys_clk,
  input  wire        rst_n,
  // instruction side
  input  wire        cyc_en,
  input  wire        instr_valid,
  input  wire [13:0] instr_word,
  // register file side
  input  wire [7:0]  reg_rdata,
  input  wire        reg_is_port,
  input  wire [7:0]  port_pins,
  // results, all straight from flip-flops
  output reg  [6:0]  reg_addr,
  output reg         reg_we,
  output reg  [7:0]  reg_wdata,
  output reg  [7:0]  acc_w,
  output reg         carry_flag,
  output reg         nibble_out_flag,
  output reg         zero_flag,
  output reg         squash_next,
  output reg         illegal_op
);

  // instruction fields
  wire [1:0] cls      = instr_word[13:12];
  wire [3:0] byte_op  = instr_word[11:8];
  wire [1:0] bit_op   = instr_word[11:10];
  wire [2:0] bit_idx  = instr_word[9:7];
  wire [6:0] f_addr   = instr_word[6:0];
  // destination bit 1 sends the result back to the register
  wire       dest_reg = instr_word[7];
  wire [7:0] literal  = instr_word[7:0];

  // one decode line per byte or literal instruction of this group
  wire       lit_add_hit = (cls == `BBX_LIT_CLASS) && (instr_word[11:9] == `BBX_LIT_ADD);
  wire       lit_and_hit = (cls == `BBX_LIT_CLASS) && (byte_op == `BBX_LIT_AND);
  wire       reg_add_hit = (cls == `BBX_BYTE_CLASS) && (byte_op == `BBX_BYTE_ADD);
  wire       reg_and_hit = (cls == `BBX_BYTE_CLASS) && (byte_op == `BBX_BYTE_AND);

  // read-modify-write sources a port's pins, not its latch
  wire [7:0] f_val = reg_is_port ? port_pins : reg_rdata;

  // one-hot select of the addressed bit and its tested value, one cell per data bit
  wire [7:0] bit_sel;
  wire [7:0] bit_hit;
  genvar     gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit_sel
      localparam [2:0] BIT_POS = gi;
      assign bit_sel[gi] = (bit_idx == BIT_POS);
      assign bit_hit[gi] = bit_sel[gi] & f_val[gi];
    end
  endgenerate

  // the counter covers the discarded slot that follows a taken test
  wire [31:0] skip_load_full = `BBX_SKIP_CYCLES - 1;
  wire [1:0]  skip_load      = skip_load_full[1:0];

  // reset image of the flag bits, indexed by their positions
  wire [2:0] flags_init = `BBX_FLAGS_RESET;

  reg  [1:0] skip_cnt_q;
  reg  [1:0] skip_cnt_d;
  wire       skip_slot = (skip_cnt_q != 2'h0);

  // next-state values and datapath temporaries

  reg  [7:0] w_d;
  reg        c_d;
  reg        dc_d;
  reg        z_d;
  reg        we_d;
  reg  [7:0] wdata_d;
  reg        sq_d;
  reg        ill_d;
  reg  [7:0] operand;
  reg  [4:0] low_sum;
  reg  [8:0] full_sum;
  reg  [7:0] res;
  reg  [7:0] bit_mask;
  reg        tested;

  // next-state logic; an idle slot holds W, the flags and the write data, a discarded slot holds the same while the skip counter counts down
  always @* begin
    w_d        = acc_w;
    c_d        = carry_flag;
    dc_d       = nibble_out_flag;
    z_d        = zero_flag;
    we_d       = 1'b0;
    wdata_d    = reg_wdata;
    sq_d       = 1'b0;
    ill_d      = 1'b0;
    skip_cnt_d = skip_cnt_q;
    operand    = (cls == `BBX_LIT_CLASS) ? literal : f_val;
    low_sum    = {1'b0, acc_w[3:0]} + {1'b0, operand[3:0]};
    full_sum   = {1'b0, acc_w} + {1'b0, operand};
    res        = 8'h00;
    bit_mask   = bit_sel;
    tested     = |bit_hit;
    if (skip_slot) begin
      // discarded slot runs as a no-operation
      skip_cnt_d = skip_cnt_q - 2'h1;
    end else if (instr_valid) begin
      case (cls)
        `BBX_LIT_CLASS: begin
          if (lit_add_hit) begin
            w_d  = full_sum[7:0];
            c_d  = full_sum[8];
            dc_d = low_sum[4];
            z_d  = (full_sum[7:0] == 8'h00);
          end else if (lit_and_hit) begin
            w_d = acc_w & literal;
            z_d = ((acc_w & literal) == 8'h00);
          end else begin
            ill_d = 1'b1;
          end
        end
        `BBX_BYTE_CLASS: begin
          if (reg_add_hit || reg_and_hit) begin
            if (reg_add_hit) begin
              res  = full_sum[7:0];
              c_d  = full_sum[8];
              dc_d = low_sum[4];
            end else begin
              res = acc_w & f_val;
            end
            // flags follow the result whichever way it is routed
            z_d = (res == 8'h00);
            if (dest_reg) begin
              we_d    = 1'b1;
              wdata_d = res;
            end else begin
              w_d = res;
            end
          end else begin
            ill_d = 1'b1;
          end
        end
        `BBX_BIT_CLASS: begin
          case (bit_op)
            `BBX_BIT_CLR: begin
              we_d    = 1'b1;
              wdata_d = f_val & ~bit_mask;
            end
            `BBX_BIT_SET: begin
              we_d    = 1'b1;
              wdata_d = f_val | bit_mask;
            end
            `BBX_BIT_SKIP_CLR: begin
              if (!tested) begin
                sq_d       = 1'b1;
                skip_cnt_d = skip_load;
              end
            end
            `BBX_BIT_SKIP_SET: begin
              if (tested) begin
                sq_d       = 1'b1;
                skip_cnt_d = skip_load;
              end
            end
            default: ill_d = 1'b1;
          endcase
        end
        // words outside this group change nothing and raise the flag
        default: ill_d = 1'b1;
      endcase
    end
  end

  // state updates once per instruction cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_w           <= `BBX_W_RESET;
      carry_flag      <= flags_init[`BBX_FLAG_C];
      nibble_out_flag <= flags_init[`BBX_FLAG_DC];
      zero_flag       <= flags_init[`BBX_FLAG_Z];
      reg_addr        <= 7'h00;
      reg_wdata       <= 8'h00;
      squash_next     <= 1'b0;
      illegal_op      <= 1'b0;
      skip_cnt_q      <= 2'h0;
    end else if (cyc_en) begin
      acc_w           <= w_d;
      carry_flag      <= c_d;
      nibble_out_flag <= dc_d;
      zero_flag       <= z_d;
      reg_addr        <= f_addr;
      reg_wdata       <= wdata_d;
      squash_next     <= sq_d;
      illegal_op      <= ill_d;
      skip_cnt_q      <= skip_cnt_d;
    end
  end

  // write strobe is one sys_clk wide regardless of cycle rate; the write lands at the
  // next edge, so with cyc_en high every sys_clk a register rewritten by one word reads old data in the very next word
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_we <= 1'b0;
    end else begin
      reg_we <= cyc_en & we_d;
    end
  end

endmodule // bbx_exec

// File: pkg/bbx_map.vh
// opcode fields, flag positions and timing constants for the byte/bit execute unit
`ifndef BBX_MAP_VH
`define BBX_MAP_VH
`define BBX_OPW            14
`define BBX_ADDRW          7
`define BBX_BIT_CLASS      2'h1
`define BBX_BIT_CLR        2'h0
`define BBX_BIT_SET        2'h1
`define BBX_BIT_SKIP_CLR   2'h2
`define BBX_BIT_SKIP_SET   2'h3
`define BBX_BYTE_CLASS     2'h0
`define BBX_BYTE_ADD       4'h7
`define BBX_BYTE_AND       4'h5
`define BBX_LIT_CLASS      2'h3
`define BBX_LIT_ADD        3'h7
`define BBX_LIT_AND        4'h9
`define BBX_FLAG_C         0
`define BBX_FLAG_DC        1
`define BBX_FLAG_Z         2
`define BBX_W_RESET        8'h00
`define BBX_FLAGS_RESET    3'h0
`define BBX_SKIP_CYCLES    2
`endif

// File: sim/bbx_exec_properties.sv
// concurrent checks on the byte/bit execute unit ports
`timescale 1ns/1ps
module bbx_exec_properties (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        cyc_en,
  input wire        instr_valid,
  input wire        reg_is_port,
  input wire        reg_we,
  input wire        squash_next,
  input wire [13:0] instr_word,
  input wire [7:0]  reg_rdata,
  input wire [7:0]  port_pins,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  acc_w
);
  wire [7:0] opd = reg_is_port ? port_pins : reg_rdata;
  wire [2:0] b   = instr_word[9:7];
  wire [7:0] k   = instr_word[7:0];
  wire [3:0] op  = instr_word[13:10];
  wire       hit = opd[b];
  wire       tk  = cyc_en && instr_valid && !squash_next;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_skip; tk && op[3:1] == 3'h3 && hit == op[0] ##1 squash_next; endsequence
  a_add_imm: assert property (tk && op == 4'hF && b[2] |=>
    acc_w == $past(acc_w) + $past(k)) else $error("add immediate sum");
  a_add_reg: assert property (tk && op == 4'h1 && b == 3'h7 |=>
    reg_we && reg_wdata == $past(acc_w) + $past(opd)) else $error("add register sum");
  a_and_imm: assert property (tk && op == 4'hE && b[2:1] == 2'h1 |=>
    acc_w == ($past(acc_w) & $past(k))) else $error("and immediate result");
  a_bit_clr: assert property (tk && op == 4'h4 |=> reg_we && !reg_wdata[$past(b)])
    else $error("bit clear");
  a_bit_set: assert property (tk && op == 4'h5 |=> reg_we && reg_wdata[$past(b)])
    else $error("bit set");
  a_skip_one: assert property (tk && op == 4'h7 |=> squash_next == $past(hit))
    else $error("skip if one");
  a_skip_zero: assert property (tk && op == 4'h6 |=> squash_next != $past(hit))
    else $error("skip if zero");
  a_skip_nop: assert property (s_skip |=> !reg_we && $stable(acc_w))
    else $error("discarded word acted");
endmodule // bbx_exec_properties
bind bbx_exec bbx_exec_properties u_props (.*);

// File: sim/bbx_rf_model.sv
// data register file standing behind the execute unit
`timescale 1ns/1ps
module bbx_rf_model (
  input  wire       sys_clk, reg_we,
  input  wire [6:0] reg_addr, rd_addr,
  input  wire [7:0] reg_wdata,
  output wire [7:0] reg_rdata
);
  reg [7:0] mem_q [0:127];
  integer   i;
  initial for (i = 0; i < 128; i = i + 1) mem_q[i] = i * 37;
  assign reg_rdata = mem_q[rd_addr];
  always @(posedge sys_clk) if (reg_we) mem_q[reg_addr] <= reg_wdata;
endmodule // bbx_rf_model

// File: sim/bbx_exec_tb.sv
// self-checking bench: random instruction stream against an integer model
`timescale 1ns/1ps
module bbx_exec_tb;
  reg        sys_clk = 0, rst_n = 0, instr_valid = 0, reg_is_port = 0;
  reg [13:0] instr_word = 0;
  reg [7:0]  port_pins = 0;
  wire [6:0] reg_addr;
  wire [7:0] reg_rdata, reg_wdata, acc_w;
  wire       reg_we, carry_flag, nibble_out_flag, zero_flag, squash_next, illegal_op;
  integer seed = 58, num_errors = 0, checked = 0, cyc = 0, i, kd, o, n, s, p;
  integer ea = 0, ec = 0, edc = 0, ez = 0, ew = 0, ed = 0, esq = 0;
  initial forever #4 sys_clk = ~sys_clk;
  bbx_exec uut (.*, .cyc_en(1'b1));
  bbx_rf_model rf (.*, .rd_addr(instr_word[6:0]));
  task wrap_up; begin
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end endtask
  task cmp(input [31:0] got, exp); begin
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  // ceiling well above the 400 driven cycles
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc > 2000) begin num_errors = num_errors + 1; wrap_up; end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1;
    for (i = 0; i < 400; i = i + 1) begin
      kd = $random(seed) & 7;
      instr_valid = ($random(seed) & 7) != 0;
      reg_is_port = $random(seed);
      port_pins = $random(seed);
      case (kd)
        0: s = 14'h3E00; 1: s = 14'h3900; 2: s = 14'h0700; 3: s = 14'h0500;
        default: s = 14'h1000 + (kd - 4) * 1024;
      endcase
      instr_word = s | ($random(seed) & (kd < 4 ? 14'h00FF : 14'h03FF));
      #1 o = reg_is_port ? port_pins : reg_rdata;
      n = kd < 2 ? instr_word[7:0] : o;
      p = esq; ew = 0; esq = 0;
      if (p || !instr_valid) ;
      else if (kd > 5) esq = o[instr_word[9:7]] == instr_word[10];
      else if (kd > 3) begin
        ew = 1;
        ed = kd == 5 ? o | 1 << instr_word[9:7] : o & ~(1 << instr_word[9:7]);
      end else begin
        ew = kd > 1 && instr_word[7];
        s = kd[0] ? ea & n : ea + n;
        ez = (s & 255) == 0;
        if (!kd[0]) begin ec = s > 255; edc = (ea & 15) + (n & 15) > 15; end
        if (ew) ed = s; else ea = s & 255;
      end
      @(posedge sys_clk);
      #1 cmp({acc_w, carry_flag, nibble_out_flag, zero_flag, reg_we, squash_next, illegal_op},
             {ea[7:0], ec[0], edc[0], ez[0], ew[0], esq[0], 1'b0});
      if (ew) cmp({reg_addr, reg_wdata}, {instr_word[6:0], ed[7:0]});
    end
    // idle slot drains any pending skip, then a word outside the group
    instr_valid = 0;
    @(posedge sys_clk);
    #1 instr_valid = 1;
    instr_word = 14'h2ABC;
    @(posedge sys_clk);
    #1 cmp({acc_w, reg_we, squash_next, illegal_op}, {ea[7:0], 3'h1});
    // reset in mid-run clears everything, then the first word after release executes
    rst_n = 0;
    @(posedge sys_clk);
    #1 cmp({acc_w, carry_flag, nibble_out_flag, zero_flag, reg_we, squash_next, illegal_op},
           14'h0000);
    rst_n = 1;
    instr_word = 14'h3E05;
    @(posedge sys_clk);
    #1 cmp({acc_w, carry_flag, nibble_out_flag, zero_flag}, 11'h028);
    wrap_up;
  end
endmodule // bbx_exec_tb
